// >>> mpmp_mem_model.sv
// external address latch plus asynchronous memory on the muxed bus
// assumes it samples on the core clock; pins come straight from the port
`timescale 1ns/1ns
module mpmp_mem_model (
  input wire logic clk,
  input wire logic ale_low,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] bus_out,
  input wire logic [15:0] bus_oe,
  output logic [15:0] bus_in,
  output logic [15:0] latched_addr,
  output logic [15:0] last_wdata
);
  logic [15:0] junk = 16'h0000;
  logic [15:0] mem_drive;
  // latch stays transparent while the pulse is active, keeps the last address
  always @(posedge clk) begin
    if (ale ^ ale_low) latched_addr <= bus_out;
    if (!wr_n) last_wdata <= bus_out; // last value before the strobe rises
    junk <= ~junk; // a released bus never shows a steady value
  end
  // read data only while the strobe is low; no hold after it rises
  assign mem_drive = !rd_n ? (latched_addr ^ 16'hc3a5) : junk;
  assign bus_in = (bus_out & bus_oe) | (mem_drive & ~bus_oe);
endmodule

// >>> mpmp_pkg.sv
// types for the muxed parallel memory port
// assumes mpmp_regs.svh is included where constants are needed
package mpmp_pkg;
  typedef struct packed {
    logic [15:0] ctrl;
    logic wide16;
    logic hold_en;
    logic ale_low;
    logic flash_en;
    logic [1:0] pack_mode;
  } mpmp_cfg_t;
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [2:0] count;
  } mpmp_req_t;
  typedef enum logic [2:0] {
    MPMP_IDLE, MPMP_ALE, MPMP_SETUP, MPMP_STROBE, MPMP_HOLD, MPMP_RECOVER, MPMP_GAP
  } mpmp_state_t;
endpackage

// >>> mpmp_port.sv
// muxed address/data external memory port sequencer
// assumes cfg and req are synchronous to clk (core clock); bus pin input from outside
`timescale 1ns/1ns
`include "mpmp_regs.svh"
module mpmp_port
  import mpmp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire mpmp_cfg_t cfg,
  input wire logic req_valid,
  input wire mpmp_req_t req,
  output logic req_ready,
  output logic [15:0] rdata,
  output logic rdata_valid,
  output logic done,
  input wire logic [15:0] bus_in,
  output logic [15:0] bus_out,
  output logic [15:0] bus_oe,
  output logic ale,
  output logic rd_n,
  output logic wr_n
);
  mpmp_state_t state;
  mpmp_cfg_t acfg;
  mpmp_req_t areq;
  logic pclk_ph;
  logic pclk_tick;
  logic [4:0] cnt;
  logic [2:0] left;
  logic [15:0] bus_s1;
  logic [15:0] bus_s2;
  logic rd_phase;
  logic last_step;

  // strobe length field of a control word
  function automatic logic [4:0] len_of(input logic [15:0] c);
    len_of = c[`MPMP_LEN_MSB:`MPMP_LEN_LSB];
  endfunction

  // strobes in one burst from width, packing mode and request count
  function automatic logic [2:0] burst_of(input mpmp_cfg_t c, input logic [2:0] n);
    if (!c.wide16) begin
      burst_of = `MPMP_BURST8;
    end else if (c.pack_mode != 2'h0) begin
      burst_of = 3'h1;
    end else begin
      burst_of = (n == 3'h0) ? 3'h1 : n;
    end
  endfunction

  // peripheral clock phase: one tick every two core clocks
  always_ff @(posedge clk) begin
    if (srst) begin
      pclk_ph <= 1'b0;
    end else begin
      pclk_ph <= ~pclk_ph;
    end
  end
  assign pclk_tick = pclk_ph;

  // two-flop synchroniser on the bus pins; only stage two is read
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_s1 <= 16'h0000;
      bus_s2 <= 16'h0000;
    end else begin
      bus_s1 <= bus_in;
      bus_s2 <= bus_s1;
    end
  end

  // access sequencer, counts whole peripheral clocks per state
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= MPMP_IDLE;
      cnt <= 5'h00;
      left <= 3'h0;
      acfg <= '0;
      areq <= '0;
    end else if (state == MPMP_IDLE) begin
      if (req_valid && pclk_tick) begin
        acfg <= cfg;
        areq <= req;
        left <= burst_of(cfg, req.count);
        cnt <= `MPMP_ALE_PCLKS;
        state <= MPMP_ALE;
      end
    end else if (pclk_tick) begin
      if (cnt > 5'h01) begin
        cnt <= cnt - 5'h01;
      end else begin
        unique case (state)
          MPMP_ALE: begin
            cnt <= `MPMP_SETUP_PCLKS;
            state <= MPMP_SETUP;
          end
          MPMP_SETUP, MPMP_GAP: begin
            // flash writes lose the recovery clocks out of D; D >= 9 is software's job
            if (areq.write && acfg.flash_en) begin
              cnt <= len_of(acfg.ctrl) - `MPMP_FLASH_PCLKS;
            end else begin
              cnt <= (len_of(acfg.ctrl) == 5'h00) ? 5'h01 : len_of(acfg.ctrl);
            end
            state <= MPMP_STROBE;
          end
          MPMP_STROBE: begin
            left <= left - 3'h1;
            if (acfg.hold_en) begin
              cnt <= 5'h01;
              state <= MPMP_HOLD;
            end else if (acfg.flash_en && (areq.write || left == 3'h1)) begin
              cnt <= `MPMP_FLASH_PCLKS;
              state <= MPMP_RECOVER;
            end else if (left != 3'h1) begin
              cnt <= 5'h01;
              state <= MPMP_GAP;
            end else begin
              state <= MPMP_IDLE;
            end
          end
          MPMP_HOLD: begin
            // reads recover only after the last strobe; writes after every strobe
            if (acfg.flash_en && (areq.write || left == 3'h0)) begin
              cnt <= `MPMP_FLASH_PCLKS;
              state <= MPMP_RECOVER;
            end else if (left != 3'h0) begin
              cnt <= 5'h01;
              state <= MPMP_GAP;
            end else begin
              state <= MPMP_IDLE;
            end
          end
          MPMP_RECOVER: begin
            if (left != 3'h0) begin
              cnt <= 5'h01;
              state <= MPMP_GAP;
            end else begin
              state <= MPMP_IDLE;
            end
          end
          default: begin
            state <= MPMP_IDLE;
          end
        endcase
      end
    end
  end

  // read strobe flag, one core clock late, marks when to capture read data
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_phase <= 1'b0;
    end else begin
      rd_phase <= (state == MPMP_STROBE) && !areq.write;
    end
  end

  // pin drivers, all registered; latch polarity resets to active high
  always_ff @(posedge clk) begin
    if (srst) begin
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      bus_out <= 16'h0000;
      bus_oe <= 16'h0000;
    end else begin
      // idle level tracks live polarity one core clock late, so a repolarised latch sees at most a one-clock stray pulse
      ale <= (state == MPMP_ALE) ^ ((state == MPMP_IDLE) ? cfg.ale_low : acfg.ale_low);
      rd_n <= !((state == MPMP_STROBE) && !areq.write);
      wr_n <= !((state == MPMP_STROBE) && areq.write);
      if (state == MPMP_ALE) begin
        bus_out <= areq.addr;
        bus_oe <= 16'hffff;
      end else if (areq.write && state != MPMP_IDLE) begin
        // data held through hold state 8-bit keeps upper address
        bus_out <= acfg.wide16 ? areq.wdata : {areq.addr[15:8], areq.wdata[7:0]};
        bus_oe <= 16'hffff;
      end else if (state == MPMP_SETUP || state == MPMP_STROBE) begin
        // read: release data lines after latch; 8-bit keeps upper address lines
        bus_out <= {areq.addr[15:8], 8'h00};
        bus_oe <= acfg.wide16 ? 16'h0000 : 16'hff00;
      end else begin
        bus_out <= 16'h0000;
        bus_oe <= 16'h0000;
      end
    end
  end

  // read capture at the strobe rise, from the synchronised bus
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 16'h0000;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= rd_phase && (state != MPMP_STROBE);
      if (rd_phase && state != MPMP_STROBE) begin
        rdata <= acfg.wide16 ? bus_s2 : {8'h00, bus_s2[7:0]};
      end
    end
  end

  // final peripheral clock of an access; must mirror every exit to idle above
  assign last_step = pclk_tick && (cnt <= 5'h01) &&
    ((state == MPMP_STROBE && !acfg.hold_en && !acfg.flash_en && left == 3'h1) ||
     (state == MPMP_HOLD && !acfg.flash_en && left == 3'h0) ||
     (state == MPMP_RECOVER && left == 3'h0));

  // handshake outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      req_ready <= 1'b0;
      done <= 1'b0;
    end else begin
      req_ready <= (state == MPMP_IDLE) && !(req_valid && pclk_tick);
      done <= last_step;
    end
  end

  property p_ale_len;
    @(posedge clk) disable iff (srst)
      $rose(state == MPMP_ALE) |-> (state == MPMP_ALE) [*4] ##1 (state == MPMP_SETUP);
  endproperty
  a_ale_len: assert property (p_ale_len) else $error("latch not two pclks");

  property p_setup_len;
    @(posedge clk) disable iff (srst)
      $rose(state == MPMP_SETUP) |-> (state == MPMP_SETUP) [*4] ##1 (state == MPMP_STROBE);
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("strobe delay wrong");

  property p_rst_pol;
    @(posedge clk) disable iff (srst)
      (state == MPMP_IDLE && !cfg.ale_low) |-> ##1 !ale;
  endproperty
  a_rst_pol: assert property (p_rst_pol) else $error("latch polarity wrong");

  property p_hold_len;
    @(posedge clk) disable iff (srst)
      $rose(state == MPMP_HOLD) |-> (state == MPMP_HOLD) [*2] ##1 (state != MPMP_HOLD);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold not one pclk");

  property p_flash_len;
    @(posedge clk) disable iff (srst)
      $rose(state == MPMP_RECOVER) |-> (state == MPMP_RECOVER) [*8] ##1
        (state == MPMP_RECOVER) [*6] ##1 (state != MPMP_RECOVER);
  endproperty
  a_flash_len: assert property (p_flash_len) else $error("recovery not 7 pclks");

  property p_release;
    @(posedge clk) disable iff (srst)
      (state == MPMP_SETUP && !areq.write && acfg.wide16) |-> ##1 (bus_oe == 16'h0000);
  endproperty
  a_release: assert property (p_release) else $error("bus not released on read");

  property p_wdata;
    @(posedge clk) disable iff (srst)
      (state == MPMP_HOLD && areq.write) |-> ##1 (bus_oe == 16'hffff);
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data not held");

  property p_upper;
    @(posedge clk) disable iff (srst)
      (state == MPMP_STROBE && areq.write && !acfg.wide16) |-> ##1
        (bus_out[15:8] == areq.addr[15:8]);
  endproperty
  a_upper: assert property (p_upper) else $error("upper address lost");

  property p_burst8;
    @(posedge clk) disable iff (srst)
      (state == MPMP_ALE && !acfg.wide16) |-> (left == 3'h4);
  endproperty
  a_burst8: assert property (p_burst8) else $error("8-bit burst not four");

  property p_single;
    @(posedge clk) disable iff (srst)
      (state == MPMP_ALE && acfg.wide16 && acfg.pack_mode != 2'h0) |-> (left == 3'h1);
  endproperty
  a_single: assert property (p_single) else $error("packed burst not one");

  property p_tick;
    @(posedge clk) disable iff (srst)
      $changed(state) |-> $past(pclk_tick);
  endproperty
  a_tick: assert property (p_tick) else $error("state moved off a peripheral clock");

  property p_read_rec;
    @(posedge clk) disable iff (srst)
      (state == MPMP_RECOVER && !areq.write) |-> (left == 3'h0);
  endproperty
  a_read_rec: assert property (p_read_rec) else $error("read recovery inside burst");

  property p_done;
    @(posedge clk) disable iff (srst)
      done == (state == MPMP_IDLE && $past(state) != MPMP_IDLE);
  endproperty
  a_done: assert property (p_done) else $error("done not at access end");

  property p_store_gap;
    @(posedge clk) disable iff (srst)
      (state == MPMP_GAP && areq.write && acfg.flash_en) |-> ($past(state, 2) == MPMP_RECOVER);
  endproperty
  a_store_gap: assert property (p_store_gap) else $error("write gap lacks recovery");

  property p_addr_drive;
    @(posedge clk) disable iff (srst)
      (state == MPMP_ALE) |=> (bus_oe == 16'hffff && bus_out == areq.addr);
  endproperty
  a_addr_drive: assert property (p_addr_drive) else $error("address not on bus");

  property p_pol_low;
    @(posedge clk) disable iff (srst)
      (state == MPMP_ALE && acfg.ale_low) |=> !ale;
  endproperty
  a_pol_low: assert property (p_pol_low) else $error("low latch pulse wrong");

  c_read8: cover property (@(posedge clk) state == MPMP_STROBE && !areq.write && !acfg.wide16);
  c_write16: cover property (@(posedge clk) state == MPMP_STROBE && areq.write && acfg.wide16);
  c_flash: cover property (@(posedge clk) state == MPMP_RECOVER);
  c_flash_gap: cover property (@(posedge clk) state == MPMP_GAP && areq.write && acfg.flash_en);
endmodule

// >>> mpmp_regs.svh
// timing constants and field layout for the muxed parallel memory port
// assumes inclusion once per compile unit
`ifndef MPMP_REGS_SVH
`define MPMP_REGS_SVH
`define MPMP_LEN_MSB 5
`define MPMP_LEN_LSB 1
`define MPMP_CTRL_RST 16'h0000
`define MPMP_PCLK_DIV 2
`define MPMP_ALE_PCLKS 5'h02
`define MPMP_SETUP_PCLKS 5'h02
`define MPMP_FLASH_PCLKS 5'h07
`define MPMP_BURST8 3'h4
`endif

// >>> tb_mpmp_port.sv
// self-checking bench for the muxed parallel memory port
// assumes mpmp_pkg compiled first and the memory model beside it
`timescale 1ns/1ns
module tb_mpmp_port;
  import mpmp_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  mpmp_cfg_t cfg = '0;
  logic req_valid = 1'b0;
  mpmp_req_t req = '0;
  logic req_ready, rdata_valid, done, ale, rd_n, wr_n;
  logic [15:0] rdata, bus_in, bus_out, bus_oe, latched_addr, last_wdata;
  logic [15:0] msk = 16'hffff;
  int errors = 0;
  int tests_run = 0;
  int strobes, cur, wid, hi, gap, alec, lead;

  always #25 clk = ~clk;

  mpmp_port dut (.clk(clk), .srst(srst), .cfg(cfg), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid), .done(done),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n));
  mpmp_mem_model mem (.clk(clk), .ale_low(cfg.ale_low), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .bus_out(bus_out), .bus_oe(bus_oe), .bus_in(bus_in),
    .latched_addr(latched_addr), .last_wdata(last_wdata));

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // pin monitor: strobe count, width, gaps, latch pulse and lead-in, read data
  always @(posedge clk) begin
    if (!rd_n || !wr_n) begin
      if (cur == 0) begin
        strobes++;
        if (strobes > 1) gap = hi;
        if (!wr_n && !cfg.wide16)
          check("upper addr", {8'h00, bus_out[15:8]}, {8'h00, req.addr[15:8]});
      end
      cur++;
      hi = 0;
    end else begin
      if (cur != 0) wid = cur;
      cur = 0;
      hi++;
    end
    if (alec > 0 && strobes == 0 && !(ale ^ cfg.ale_low)) lead++;
    if (ale ^ cfg.ale_low) alec++;
    if (rdata_valid) check("rdata", rdata & msk, (latched_addr ^ 16'hc3a5) & msk);
  end

  // one access with its expected strobe pattern; flash runs keep D at 9 or more
  task automatic run(input logic w, input logic wd, input logic [1:0] pk, input logic hd,
    input logic al, input logic fl, input logic [4:0] d, input logic [2:0] n,
    input int exp_n);
    int k;
    // config settles one cycle before counting, so a polarity change is not seen as a pulse
    @(posedge clk);
    #1 cfg = '{ctrl: {10'h000, d, 1'b0}, wide16: wd, hold_en: hd, ale_low: al,
      flash_en: fl, pack_mode: pk};
    req = '{write: w, addr: 16'h9a30 + 16'(n), wdata: 16'h5c17 + 16'(n), count: n};
    msk = wd ? 16'hffff : 16'h00ff;
    @(posedge clk);
    #1 strobes = 0;
    alec = 0;
    lead = 0;
    gap = 0;
    req_valid = 1'b1;
    k = 0;
    // ready drops just after the edge that took the request
    do begin
      @(posedge clk);
      #1 k++;
    end while (req_ready !== 1'b0 && k < 50);
    req_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1 k++;
    end
    check("done", {15'h0000, done}, 16'h0001);
    // the last strobe may still be low when done shows; let the monitor close it
    repeat (2) @(posedge clk);
    #1 check("strobes", 16'(strobes), 16'(exp_n));
    check("width", 16'(wid), 16'(2 * ((w && fl) ? d - 7 : d)));
    if (exp_n > 1)
      check("gap", 16'(gap), 16'(2 * (1 + hd + ((w && fl) ? 7 : 0))));
    check("ale width", 16'(alec), 16'h0004);
    check("lead", 16'(lead), 16'h0004);
    if (w) check("wdata", last_wdata & msk, req.wdata & msk);
    repeat (4) @(posedge clk);
  endtask

  // watchdog well beyond the longest access sequence
  initial begin
    #2000000;
    errors++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1 srst = 1'b0;
    repeat (2) @(posedge clk);
    #1 check("idle ale", {15'h0000, ale}, 16'h0000);
    check("idle strobes", {14'h0000, rd_n, wr_n}, 16'h0003);
    run(1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 5'h03, 3'h0, 4);
    run(1'b1, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 5'h02, 3'h0, 4);
    run(1'b0, 1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 5'h04, 3'h3, 1);
    run(1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 5'h02, 3'h3, 3);
    run(1'b0, 1'b1, 2'h0, 1'b1, 1'b1, 1'b1, 5'h09, 3'h2, 2);
    run(1'b1, 1'b1, 2'h2, 1'b1, 1'b1, 1'b1, 5'h09, 3'h0, 1);
    run(1'b1, 1'b1, 2'h3, 1'b0, 1'b0, 1'b0, 5'h05, 3'h0, 1);
    run(1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1, 5'h09, 3'h0, 4);
    stop_test();
  end
endmodule
